/* File: rtl/mcs_pkg.sv */
package mcs_pkg;
	// register indices on the plain register port
	localparam logic [1:0] ADDR_HIGH_CTRL = 2'h0;
	localparam logic [1:0] ADDR_LOW_CTRL = 2'h1;
	localparam logic [1:0] ADDR_STATUS = 2'h2;
	// field positions inside each carrier control register
	localparam int BIT_PIN_OFF = 7;
	localparam int BIT_INVERT = 6;
	localparam int BIT_EDGE_WAIT = 5;
	localparam int BIT_UNUSED = 4;
	localparam int SRC_MSB = 3;
	// reset value of both control registers (documented value unknown)
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// writable bits: bit 4 is not implemented
	localparam logic [7:0] CTRL_WMASK = 8'hEF;
	localparam logic [3:0] SRC_CONST_LOW = 4'h0;

	// one carrier control register, as fields
	typedef struct packed {
		logic pin_output_off;
		logic invert;
		logic edge_wait;
		logic unused;
		logic [3:0] source_sel;
	} mcs_ctrl_t;

	// carrier selection state
	typedef enum logic [1:0] {
		MCS_ON_LOW = 2'b00,
		MCS_ON_HIGH = 2'b01,
		MCS_WAIT_LOW = 2'b10,
		MCS_WAIT_HIGH = 2'b11
	} mcs_state_t;
endpackage : mcs_pkg

/* File: rtl/mcs_carrier_path.sv */
`timescale 1ns/100ps
// one carrier path: source mux, polarity and falling-edge detect
module mcs_carrier_path #(
	parameter int N_SRC = 16
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// configuration and sources
	input wire mcs_pkg::mcs_ctrl_t i_ctrl,
	input wire logic [N_SRC-1:0] i_sources,
	// result
	output logic o_carrier,
	output logic o_fall
);
	import mcs_pkg::*;

	logic sel_now;
	logic prev;
	logic next_prev;

	// code zero gives constant low; unconnected codes should be tied low
	always_comb begin
		if (i_ctrl.source_sel == SRC_CONST_LOW) begin
			sel_now = 1'b0;
		end else begin
			sel_now = i_sources[i_ctrl.source_sel];
		end
		o_carrier = sel_now ^ i_ctrl.invert;
		next_prev = o_carrier;
		o_fall = prev & ~o_carrier;
	end

	// previous level, for the falling-edge test
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev <= 1'b0;
		end else if (i_ce) begin
			prev <= next_prev;
		end
	end
endmodule : mcs_carrier_path

/* File: rtl/mcs_carrier_select.sv */
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// Contract
// - Low control bit 6 inverts the selected low carrier.
// - With low bit 5 set, a switch low to high waits for a low-carrier fall.
// - With low bit 5 clear, the switch away from low is immediate.
// - Bit 4 of each control register reads zero and ignores writes.
// - With high bit 5 set, a switch high to low waits for a high-carrier fall.
// - High control bit 6 inverts the selected high carrier.
module mcs_carrier_select #(
	parameter int N_SRC = 16
) (
	// clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_ce,
	// register port
	input wire logic [1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// modulation data and carrier sources
	input wire logic i_mod_bit,
	input wire logic [N_SRC-1:0] i_sources,
	// modulator outputs
	output logic o_carrier_out,
	output logic o_high_active,
	output logic o_low_pin_oe,
	output logic o_high_pin_oe
);
	import mcs_pkg::*;

	////////////////////////////////////////////////////////////////////
	// reset release through two flops
	// assertion reaches every flop at once; the release is retimed
	// so that no flop leaves reset on another edge than its neighbours
	// the clock enable is not used here, so a reset always completes
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////
	// control registers
	mcs_ctrl_t high_ctrl;
	mcs_ctrl_t low_ctrl;
	mcs_ctrl_t next_high_ctrl;
	mcs_ctrl_t next_low_ctrl;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic rd_q;
	logic next_rd_q;
	mcs_state_t state;
	mcs_state_t next_state;

	// masking bit 4 keeps the unimplemented bit at zero
	function automatic mcs_ctrl_t wr_ctrl(input logic [7:0] d);
		wr_ctrl = mcs_ctrl_t'(d & CTRL_WMASK);
	endfunction : wr_ctrl

	// one write strobe aimed at one register index
	function automatic logic wr_hit(input logic wr, input logic [1:0] a,
		input logic [1:0] idx);
		wr_hit = wr && (a == idx);
	endfunction : wr_hit

	// the high state and its wait state both keep the high carrier
	// on the output; the wait only delays the hand-over
	function automatic logic is_high_side(input mcs_state_t s);
		is_high_side = (s == MCS_ON_HIGH) || (s == MCS_WAIT_HIGH);
	endfunction : is_high_side

	always_comb begin
		next_high_ctrl = high_ctrl;
		next_low_ctrl = low_ctrl;
		next_rdata = rdata;
		// the read strobe, registered one cycle late, marks the one cycle in which data stands
		next_rd_q = i_rd;
		if (wr_hit(i_wr, i_addr, ADDR_HIGH_CTRL)) begin
			next_high_ctrl = wr_ctrl(i_wdata);
		end
		if (wr_hit(i_wr, i_addr, ADDR_LOW_CTRL)) begin
			next_low_ctrl = wr_ctrl(i_wdata);
		end
		if (i_rd) begin
			case (i_addr)
				ADDR_HIGH_CTRL: next_rdata = high_ctrl;
				ADDR_LOW_CTRL: next_rdata = low_ctrl;
				ADDR_STATUS: next_rdata = {6'h00, state};
				// index 3 is a hole in the map and reads as zero
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// read data stands in the cycle after the read strobe only;
	// a later read of the same register returns the value then current
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			high_ctrl <= mcs_ctrl_t'(CTRL_RESET);
			low_ctrl <= mcs_ctrl_t'(CTRL_RESET);
			rdata <= 8'h00;
			rd_q <= 1'b0;
		end else if (i_ce) begin
			high_ctrl <= next_high_ctrl;
			low_ctrl <= next_low_ctrl;
			rdata <= next_rdata;
			rd_q <= next_rd_q;
		end
	end
	assign o_rdata = rd_q ? rdata : 8'h00;

	////////////////////////////////////////////////////////////////////
	// carrier paths
	// both paths run all the time, so each edge detector holds the
	// last level of its carrier even while the other one is selected
	logic low_car;
	logic low_fall;
	logic high_car;
	logic high_fall;

	mcs_carrier_path #(.N_SRC(N_SRC)) u_low (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_ctrl(low_ctrl),
		.i_sources(i_sources),
		.o_carrier(low_car),
		.o_fall(low_fall)
	);

	mcs_carrier_path #(.N_SRC(N_SRC)) u_high (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.i_ce(i_ce),
		.i_ctrl(high_ctrl),
		.i_sources(i_sources),
		.o_carrier(high_car),
		.o_fall(high_fall)
	);

	////////////////////////////////////////////////////////////////////
	// carrier switch: modulation bit high selects high carrier
	always_comb begin
		next_state = state;
		case (state)
			MCS_ON_LOW: begin
				if (i_mod_bit) begin
					// no edge wait: leave at once, short pulses accepted
					if (!low_ctrl.edge_wait) begin
						next_state = MCS_ON_HIGH;
					end else if (low_fall) begin
						next_state = MCS_ON_HIGH;
					end else begin
						next_state = MCS_WAIT_LOW;
					end
				end
			end
			MCS_WAIT_LOW: begin
				// a request withdrawn while waiting keeps the low carrier
				if (!i_mod_bit) begin
					next_state = MCS_ON_LOW;
				end else if (low_fall || !low_ctrl.edge_wait) begin
					next_state = MCS_ON_HIGH;
				end
			end
			MCS_ON_HIGH: begin
				if (!i_mod_bit) begin
					if (!high_ctrl.edge_wait || high_fall) begin
						next_state = MCS_ON_LOW;
					end else begin
						next_state = MCS_WAIT_HIGH;
					end
				end
			end
			MCS_WAIT_HIGH: begin
				// a request withdrawn while waiting keeps the high carrier
				if (i_mod_bit) begin
					next_state = MCS_ON_HIGH;
				end else if (high_fall || !high_ctrl.edge_wait) begin
					next_state = MCS_ON_LOW;
				end
			end
			default: next_state = MCS_ON_LOW;
		endcase
	end

	// output follows the next-state choice, so it changes on the same edge as the state
	logic car_out;
	logic next_car_out;
	// registering costs one cycle of latency but keeps glitches of the
	// source mux off the modulator output
	assign next_car_out = is_high_side(next_state) ? high_car : low_car;

	// state and carrier output share one register stage
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= MCS_ON_LOW;
			car_out <= 1'b0;
		end else if (i_ce) begin
			state <= next_state;
			car_out <= next_car_out;
		end
	end

	// modulator side outputs
	assign o_carrier_out = car_out;
	assign o_high_active = is_high_side(state);
	// pin enables only follow the register bits; the pin multiplexer
	// that routes the chosen source to a pad lies outside this block
	assign o_low_pin_oe = ~low_ctrl.pin_output_off;
	assign o_high_pin_oe = ~high_ctrl.pin_output_off;
endmodule : mcs_carrier_select

/* File: dv/mcs_carrier_select_assertions.sv */
`timescale 1ns/100ps
module mcs_carrier_select_assertions #(
	parameter int N_SRC = 16
) (
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_ce,
	// register port
	input wire logic [1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// carrier side
	input wire logic i_mod_bit,
	input wire logic [N_SRC-1:0] i_sources,
	input wire logic o_carrier_out,
	input wire logic o_high_active,
	input wire logic o_low_pin_oe
);
	import mcs_pkg::*;
	logic [7:0] lo, hi;
	// shadow copies, updated on the same edge as the design
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			lo <= CTRL_RESET;
			hi <= CTRL_RESET;
		end else if (i_wr && i_ce) begin
			if (i_addr == ADDR_LOW_CTRL) lo <= i_wdata & CTRL_WMASK;
			if (i_addr == ADDR_HIGH_CTRL) hi <= i_wdata & CTRL_WMASK;
		end
	end
	// code zero must give a steady level, low unless bit 6 inverts it, whatever bit 0 carries
	wire lx = ((lo[3:0] != 4'h0) && i_sources[lo[3:0]]) ^ lo[6];
	wire hx = ((hi[3:0] != 4'h0) && i_sources[hi[3:0]]) ^ hi[6];
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_nrst);
	sequence s_to_high;
		$rose(o_high_active) && $past(lo[5]);
	endsequence
	sequence s_to_low;
		$fell(o_high_active) && $past(hi[5]);
	endsequence
	////////////////////////////////
	chk_bit4_zero:
	assert property (!o_rdata[4]) else $error("bit 4 read as one");
	chk_read_back:
	assert property (i_rd && i_ce && i_addr == ADDR_LOW_CTRL
		|=> o_rdata == $past(lo)) else $error("bad read back");
	chk_low_oe:
	assert property (i_wr && i_ce && i_addr == ADDR_LOW_CTRL
		|=> o_low_pin_oe == !$past(i_wdata[7])) else $error("bad pin oe");
	chk_low_path:
	assert property ($past(!o_high_active && i_ce) && !o_high_active
		&& $stable(lo) |-> o_carrier_out == $past(lx))
		else $error("bad low carrier");
	chk_high_path:
	assert property ($past(o_high_active && i_ce) && o_high_active
		&& $stable(hi) |-> o_carrier_out == $past(hx))
		else $error("bad high carrier");
	chk_low_wait:
	assert property (s_to_high |-> $past(o_carrier_out)
		|| $past(o_carrier_out, 2)) else $error("no low fall");
	chk_high_wait:
	assert property (s_to_low |-> $past(o_carrier_out)
		|| $past(o_carrier_out, 2)) else $error("no high fall");
	chk_no_wait:
	assert property (!o_high_active && i_mod_bit && !lo[5] && i_ce
		|=> o_high_active) else $error("late switch");
endmodule : mcs_carrier_select_assertions
bind mcs_carrier_select mcs_carrier_select_assertions #(.N_SRC(N_SRC))
	u_chk (.i_mclk, .i_nrst, .i_ce, .i_addr, .i_wdata, .i_wr, .i_rd,
	.o_rdata, .i_mod_bit, .i_sources, .o_carrier_out, .o_high_active,
	.o_low_pin_oe);

/* File: dv/modulator_carrier_select_sync_tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin \
	comparisons++; \
	if ((a) !== (b)) begin \
		num_errors++; \
		$display("mismatch t=%0t got %h exp %h", $time, a, b); \
	end \
end
module modulator_carrier_select_sync_tb_top;
	import mcs_pkg::*;
	logic i_mclk, i_nrst, i_wr, i_rd, i_mod_bit, o_carrier_out;
	logic o_high_active, o_low_pin_oe, o_high_pin_oe, i_ce;
	logic [1:0] i_addr;
	logic [7:0] i_wdata, o_rdata;
	logic [15:0] i_sources;
	logic [7:0] m [4] = '{default: 8'h00};
	int num_errors = 0, comparisons = 0, seed = 64, k;
	mcs_carrier_select #(.N_SRC(16)) uut (.i_mclk, .i_nrst, .i_ce,
		.i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_mod_bit, .i_sources,
		.o_carrier_out, .o_high_active, .o_low_pin_oe, .o_high_pin_oe);
	// free-running clock
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	////////////////////////////////
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		if (a < 2) m[a] = d & CTRL_WMASK;
	endtask : wr
	task rd(input logic [1:0] a);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 `CHK(o_rdata, m[a])
		`CHK(o_low_pin_oe, ~m[1][7])
		`CHK(o_high_pin_oe, ~m[0][7])
	endtask : rd
	// carrier seen on the edge that samples its source, one edge after the source is driven
	task car(input logic [7:0] c);
		logic e;
		repeat (8) begin
			@(posedge i_mclk);
			e = ((c[3:0] != 4'h0) && i_sources[c[3:0]]) ^ c[6];
			i_sources <= 16'($random(seed));
			#1 `CHK(o_carrier_out, e)
		end
	endtask : car
	// hold the active carrier high, ask to switch, then let it fall
	task sy(input logic v, input logic [3:0] s);
		@(posedge i_mclk);
		i_sources <= 16'h0001 << s;
		i_mod_bit <= v;
		repeat (4) @(posedge i_mclk);
		i_sources <= 16'h0000;
		#1 `CHK(o_high_active, ~v)
		k = 0;
		while (o_high_active !== v && k < 4) begin
			@(posedge i_mclk);
			#1 k++;
		end
		`CHK(o_high_active, v)
	endtask : sy
	task give_verdict;
		$display("errors %0d checks %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : give_verdict
	// stop a hung run; the tests need well under 2000 cycles
	initial begin
		#20000;
		num_errors++;
		give_verdict;
	end
	// main sequence
	initial begin
		{i_nrst, i_wr, i_rd, i_mod_bit, i_addr, i_wdata} = '0;
		i_sources = 16'h0000;
		i_ce = 1'b1;
		repeat (20) @(posedge i_mclk);
		i_nrst <= 1'b1;
		repeat (3) @(posedge i_mclk);
		wr(1, 8'hFF);
		for (int t = 0; t < 6; t++) begin
			rd(0);
			rd(1);
			rd(2);
			rd(3);
			car(m[1]);
			wr(2'(t % 4), 8'($random(seed)));
		end
		$display("registers and low carrier done");
		wr(1, 8'h43);
		wr(0, 8'h45);
		@(posedge i_mclk);
		i_mod_bit <= 1'b1;
		@(posedge i_mclk);
		#1 `CHK(o_high_active, 1'b1)
		car(m[0]);
		@(posedge i_mclk);
		i_mod_bit <= 1'b0;
		$display("unsynchronised switch done");
		wr(1, 8'h21);
		wr(0, 8'h22);
		sy(1'b1, 4'h1);
		m[2] = {6'h00, MCS_ON_HIGH};
		rd(2);
		sy(1'b0, 4'h2);
		$display("synchronised switch done");
		// a write while the clock enable is low must not land
		@(posedge i_mclk);
		i_ce <= 1'b0;
		wr(1, 8'h00);
		m[1] = 8'h21;
		@(posedge i_mclk);
		i_ce <= 1'b1;
		rd(1);
		$display("clock enable freeze done");
		give_verdict;
	end
endmodule : modulator_carrier_select_sync_tb_top
